// *** inc/sfr_pkg.sv ***
// register space constants, register map and request carriers
package sfr_pkg;

  // data widths and sizes
  localparam int DATA_W = 8;
  localparam int NREG = 33;
  localparam int BUF_DEPTH = 256;
  localparam int BUF_AW = 8;
  localparam int EXTERNAL_DATA_RAM_AW = 10;

  // direct address split: upper half is the register space
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [3:0] BIT_RAM_HI = 4'h2;

  // register offsets
  localparam logic [7:0] PORT0_LATCH = 8'h80;
  localparam logic [7:0] DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] PORT0_MATCH_VALUE = 8'h84;
  localparam logic [7:0] EXT_MEMORY_CONFIG = 8'h85;
  localparam logic [7:0] LOW_FREQ_OSC_CONTROL = 8'h86;
  localparam logic [7:0] CLOCK_DIVIDE_CONTROL = 8'h8e;
  localparam logic [7:0] PORT1_LATCH = 8'h90;
  localparam logic [7:0] PORT0_OUTPUT_MODE = 8'ha4;
  localparam logic [7:0] PORT1_OUTPUT_MODE = 8'ha5;
  localparam logic [7:0] IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] CLOCK_SOURCE_SELECT = 8'ha9;
  localparam logic [7:0] EXTERNAL_DATA_RAM_PAGE_SELECT = 8'haa;
  localparam logic [7:0] PORT0_MATCH_MASK = 8'hae;
  localparam logic [7:0] EXTERNAL_OSC_CONTROL = 8'hb1;
  localparam logic [7:0] INTERNAL_OSC_CONTROL = 8'hb2;
  localparam logic [7:0] INTERNAL_OSC_CALIBRATION = 8'hb3;
  localparam logic [7:0] PORT1_MATCH_VALUE = 8'hb6;
  localparam logic [7:0] PROGRAM_MEMORY_LOCK_KEY = 8'hb7;
  localparam logic [7:0] IRQ_PRIORITY = 8'hb8;
  localparam logic [7:0] CLOCK_MULTIPLIER_CONTROL = 8'hb9;
  localparam logic [7:0] PORT1_MATCH_MASK = 8'hba;
  localparam logic [7:0] PORT0_CROSSBAR_SKIP = 8'hd4;
  localparam logic [7:0] ACCUMULATOR = 8'he0;
  localparam logic [7:0] EXT_IRQ_PIN_CONFIG = 8'he4;
  localparam logic [7:0] EXTENDED_IRQ_ENABLE_1 = 8'he6;
  localparam logic [7:0] EXTENDED_IRQ_ENABLE_2 = 8'he7;
  localparam logic [7:0] MULTIPLY_AUX_REGISTER = 8'hf0;
  localparam logic [7:0] PORT0_INPUT_MODE = 8'hf1;
  localparam logic [7:0] PORT1_INPUT_MODE = 8'hf2;
  localparam logic [7:0] IN_APP_PROGRAM_CONTROL = 8'hf5;
  localparam logic [7:0] EXTENDED_IRQ_PRIORITY_1 = 8'hf6;
  localparam logic [7:0] EXTENDED_IRQ_PRIORITY_2 = 8'hf7;

  // register map in index order
  localparam logic [7:0] SFR_ADDR [NREG] = '{
    PORT0_LATCH, DATA_POINTER_LOW, DATA_POINTER_HIGH, PORT0_MATCH_VALUE,
    EXT_MEMORY_CONFIG, LOW_FREQ_OSC_CONTROL, CLOCK_DIVIDE_CONTROL,
    PORT1_LATCH, PORT0_OUTPUT_MODE, PORT1_OUTPUT_MODE, IRQ_ENABLE,
    CLOCK_SOURCE_SELECT, EXTERNAL_DATA_RAM_PAGE_SELECT, PORT0_MATCH_MASK,
    EXTERNAL_OSC_CONTROL, INTERNAL_OSC_CONTROL, INTERNAL_OSC_CALIBRATION,
    PORT1_MATCH_VALUE, PROGRAM_MEMORY_LOCK_KEY, IRQ_PRIORITY,
    CLOCK_MULTIPLIER_CONTROL, PORT1_MATCH_MASK, PORT0_CROSSBAR_SKIP,
    ACCUMULATOR, EXT_IRQ_PIN_CONFIG, EXTENDED_IRQ_ENABLE_1,
    EXTENDED_IRQ_ENABLE_2, MULTIPLY_AUX_REGISTER, PORT0_INPUT_MODE,
    PORT1_INPUT_MODE, IN_APP_PROGRAM_CONTROL, EXTENDED_IRQ_PRIORITY_1,
    EXTENDED_IRQ_PRIORITY_2};
  localparam int CFG_IDX = 4;
  localparam int PAGE_IDX = 12;

  // field layout and reset values
  localparam int CFG_MAP_EN_BIT = 6;
  localparam logic [7:0] CFG_FIXED = 8'h03;
  localparam logic [7:0] CFG_WMASK = 8'h40;
  localparam logic [7:0] CFG_RESET = 8'h03;
  localparam logic [7:0] PAGE_WMASK = 8'h07;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FULL_WMASK = 8'hff;
  localparam logic [7:0] NO_BITS = 8'h00;

  // buffer window in external data space
  localparam logic [15:0] BUF_WIN_FIRST = 16'h0400;
  localparam logic [15:0] BUF_WIN_LAST = 16'h04ff;

  // direct access request (bit accesses carry the bit address in addr)
  typedef struct packed {
    logic valid;
    logic write;
    logic bit_acc;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dir_req_t;

  // external move request; paged uses the page select as high byte
  typedef struct packed {
    logic valid;
    logic write;
    logic paged;
    logic [15:0] addr;
    logic [7:0] wdata;
  } xmov_req_t;

  // usb engine access to the buffer
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } buf_req_t;

endpackage : sfr_pkg

// *** rtl/usb_buffer_ram.sv ***
// single port buffer memory with registered read data
`timescale 1ns/1ps
module usb_buffer_ram #(
  parameter int WIDTH = sfr_pkg::DATA_W,
  parameter int DEPTH = sfr_pkg::BUF_DEPTH,
  parameter int AW = sfr_pkg::BUF_AW
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // access port
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // storage write
  always_ff @(posedge clk_i) begin
    if (en_i && we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  // read data register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (en_i && !we_i) begin
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule : usb_buffer_ram

// *** rtl/sfr_space_and_fifo_window.sv ***
// register space decoder, register bank and buffer window steering
`timescale 1ns/1ps
//
// Behaviour
// - map enable clear: external moves never reach the buffer memory
// - map enable set: buffer appears at external addresses 0x0400..0x04ff
// - map enable set: ordinary external ram in that window is hidden
// - config bit 7 reads zero and ignores writes
// - config bits 5..0 read 000011b, ignore writes; reset value 0x03
// - direct accesses at 0x80..0xff go to register space, not data ram
// - bit access only at addresses ending 0x0 or 0x8; others byte only
// - each register decoded at its own address, config 0x85, page 0xaa
module sfr_space_and_fifo_window #(
  parameter int NREG = sfr_pkg::NREG
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // direct access from the core
  input wire sfr_pkg::dir_req_t dir_req_i,
  output logic [7:0] dir_rdata_o,
  output logic dir_rvalid_o,
  output logic dir_reserved_o,
  // lower data ram steering
  output logic iram_sel_o,
  output logic [7:0] iram_addr_o,
  // register values to the peripherals
  output logic [NREG*8-1:0] sfr_values_o,
  output logic usb_buffer_map_enable_o,
  // external move from the core
  input wire sfr_pkg::xmov_req_t xmov_req_i,
  output logic xmov_ready_o,
  output logic [7:0] xmov_rdata_o,
  output logic xmov_rvalid_o,
  // ordinary external ram steering
  output logic external_data_ram_sel_o,
  output logic [sfr_pkg::EXTERNAL_DATA_RAM_AW-1:0] external_data_ram_addr_o,
  // usb engine port to the buffer
  input wire sfr_pkg::buf_req_t usb_req_i,
  output logic [7:0] usb_rdata_o,
  output logic usb_rvalid_o
);

  // byte address that a direct access really touches
  function automatic logic [7:0] byte_addr(input logic bit_acc,
                                           input logic [7:0] a);
    if (!bit_acc) begin
      byte_addr = a;
    end else if (a[7]) begin
      byte_addr = {a[7:3], 3'h0};
    end else begin
      byte_addr = {sfr_pkg::BIT_RAM_HI, a[6:3]};
    end
  endfunction : byte_addr

  // register index lookup; hit is low for unoccupied addresses
  function automatic logic [6:0] reg_lookup(input logic [7:0] a);
    reg_lookup = '0;
    for (int k = 0; k < sfr_pkg::NREG; k++) begin
      if (sfr_pkg::SFR_ADDR[k] == a) begin
        reg_lookup = {1'b1, 6'(k)};
      end
    end
  endfunction : reg_lookup

  // bits that software may change in each register
  function automatic logic [7:0] wmask(input int idx);
    if (idx == sfr_pkg::CFG_IDX) begin
      wmask = sfr_pkg::CFG_WMASK;
    end else if (idx == sfr_pkg::PAGE_IDX) begin
      wmask = sfr_pkg::PAGE_WMASK;
    end else begin
      wmask = sfr_pkg::FULL_WMASK;
    end
  endfunction : wmask

  // bits that always read as one
  function automatic logic [7:0] fixed_ones(input int idx);
    if (idx == sfr_pkg::CFG_IDX) begin
      fixed_ones = sfr_pkg::CFG_FIXED;
    end else begin
      fixed_ones = sfr_pkg::NO_BITS;
    end
  endfunction : fixed_ones

  // reset value of each register
  function automatic logic [7:0] reset_val(input int idx);
    if (idx == sfr_pkg::CFG_IDX) begin
      reset_val = sfr_pkg::CFG_RESET;
    end else if (idx == sfr_pkg::PAGE_IDX) begin
      reset_val = sfr_pkg::PAGE_RESET;
    end else begin
      reset_val = sfr_pkg::REG_RESET;
    end
  endfunction : reset_val

  logic [7:0] eff_addr;
  logic in_sfr;
  logic [6:0] lookup;
  logic reg_hit;
  logic [5:0] reg_idx;
  logic [2:0] bit_pos;
  logic [7:0] reg_val [NREG];
  logic [7:0] rd_val;
  logic [7:0] dir_rdata_d;

  // direct access decode
  assign eff_addr = byte_addr(dir_req_i.bit_acc, dir_req_i.addr);
  assign in_sfr = dir_req_i.valid && eff_addr[7];
  assign lookup = reg_lookup(eff_addr);
  assign reg_hit = in_sfr && lookup[6];
  assign reg_idx = lookup[5:0];
  assign bit_pos = dir_req_i.addr[2:0];

  // lower half goes to data ram, upper half never does
  assign iram_sel_o = dir_req_i.valid && !eff_addr[7];
  assign iram_addr_o = eff_addr;

  // one storage register per mapped address
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic [7:0] val_q;
      logic [7:0] wm;
      logic wr_hit;
      // writable bits of this register, as a net so a bit can be picked
      assign wm = wmask(g);
      assign wr_hit = reg_hit && dir_req_i.write && (reg_idx == 6'(g));
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          val_q <= reset_val(g) & wmask(g);
        end else if (wr_hit && dir_req_i.bit_acc) begin
          val_q[bit_pos] <= dir_req_i.wdata[0] & wm[bit_pos];
        end else if (wr_hit) begin
          val_q <= dir_req_i.wdata & wmask(g);
        end
      end
      // readback merges the constant bits
      assign reg_val[g] = val_q | fixed_ones(g);
      assign sfr_values_o[g*8 +: 8] = reg_val[g];
    end
  endgenerate

  // mapping enable and page select come straight from their registers
  assign usb_buffer_map_enable_o =
    reg_val[sfr_pkg::CFG_IDX][sfr_pkg::CFG_MAP_EN_BIT];

  // read data select; bit reads return the bit in position 0
  always_comb begin
    rd_val = reg_val[reg_idx];
    if (!reg_hit) begin
      dir_rdata_d = '0;
    end else if (dir_req_i.bit_acc) begin
      dir_rdata_d = {7'h0, rd_val[bit_pos]};
    end else begin
      dir_rdata_d = rd_val;
    end
  end

  // direct read answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dir_rdata_o <= '0;
      dir_rvalid_o <= 1'b0;
    end else begin
      dir_rdata_o <= dir_rdata_d;
      dir_rvalid_o <= in_sfr && !dir_req_i.write;
    end
  end

  // flag for accesses to unoccupied addresses
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dir_reserved_o <= 1'b0;
    end else begin
      dir_reserved_o <= in_sfr && !lookup[6];
    end
  end

  logic [15:0] full_addr;
  logic in_window;
  logic buf_hit;
  logic ram_en;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic cpu_buf_rd_q;
  logic usb_rd_q;

  // external address; short form takes the page select as high byte
  assign full_addr = xmov_req_i.paged ?
    {reg_val[sfr_pkg::PAGE_IDX], xmov_req_i.addr[7:0]} :
    xmov_req_i.addr;
  assign in_window = (full_addr >= sfr_pkg::BUF_WIN_FIRST) &&
                     (full_addr <= sfr_pkg::BUF_WIN_LAST);
  assign buf_hit = xmov_req_i.valid && usb_buffer_map_enable_o &&
                   in_window;

  // usb engine owns the memory when both ask; the core waits
  assign xmov_ready_o = !(buf_hit && usb_req_i.valid);

  // ordinary ram sees everything except the mapped window
  assign external_data_ram_sel_o = xmov_req_i.valid && !buf_hit;
  assign external_data_ram_addr_o = full_addr[sfr_pkg::EXTERNAL_DATA_RAM_AW-1:0];

  // buffer port mux; usb engine first, core access only when the usb side is idle
  always_comb begin
    if (usb_req_i.valid) begin
      ram_en = 1'b1;
      ram_we = usb_req_i.write;
      ram_addr = usb_req_i.addr;
      ram_wdata = usb_req_i.wdata;
    end else begin
      ram_en = buf_hit;
      ram_we = xmov_req_i.write;
      ram_addr = full_addr[7:0];
      ram_wdata = xmov_req_i.wdata;
    end
  end

  usb_buffer_ram #(
    .WIDTH(sfr_pkg::DATA_W),
    .DEPTH(sfr_pkg::BUF_DEPTH),
    .AW(sfr_pkg::BUF_AW)
  ) u_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(ram_en),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // read answer tracking for both buffer users
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cpu_buf_rd_q <= 1'b0;
      usb_rd_q <= 1'b0;
    end else begin
      cpu_buf_rd_q <= buf_hit && xmov_ready_o && !xmov_req_i.write;
      usb_rd_q <= usb_req_i.valid && !usb_req_i.write;
    end
  end

  assign xmov_rdata_o = ram_rdata;
  assign xmov_rvalid_o = cpu_buf_rd_q;
  assign usb_rdata_o = ram_rdata;
  assign usb_rvalid_o = usb_rd_q;

  // helper state for the checks below
  logic rd_cfg_q;
  logic bit_wr_q;
  logic cfg_wr_q;
  logic cfg_wr_val_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_cfg_q <= 1'b0;
      bit_wr_q <= 1'b0;
      cfg_wr_q <= 1'b0;
      cfg_wr_val_q <= 1'b0;
    end else begin
      rd_cfg_q <= in_sfr && !dir_req_i.write &&
                  !dir_req_i.bit_acc &&
                  eff_addr == sfr_pkg::EXT_MEMORY_CONFIG;
      bit_wr_q <= reg_hit && dir_req_i.write && dir_req_i.bit_acc;
      cfg_wr_q <= in_sfr && dir_req_i.write && !dir_req_i.bit_acc &&
                  dir_req_i.addr == sfr_pkg::EXT_MEMORY_CONFIG;
      cfg_wr_val_q <= dir_req_i.wdata[sfr_pkg::CFG_MAP_EN_BIT];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  cfg_bit7_zero_a: assert property (
    rd_cfg_q |-> dir_rvalid_o && !dir_rdata_o[7])
    else $error("config bit 7 read back as one");

  cfg_low_fixed_a: assert property (
    rd_cfg_q |-> dir_rdata_o[5:0] == 6'h03)
    else $error("config low bits not 000011b");

  map_off_blocks_a: assert property (
    xmov_req_i.valid && !usb_buffer_map_enable_o && !usb_req_i.valid
    |-> !ram_en ##1 !xmov_rvalid_o)
    else $error("buffer reached with mapping disabled");

  map_window_read_a: assert property (
    xmov_req_i.valid && !xmov_req_i.write && !usb_req_i.valid &&
    usb_buffer_map_enable_o && full_addr[15:8] == 8'h04
    |-> ##1 xmov_rvalid_o)
    else $error("window read did not answer in one cycle");

  external_data_ram_hidden_a: assert property (
    xmov_req_i.valid && usb_buffer_map_enable_o &&
    full_addr[15:8] == 8'h04 |-> !external_data_ram_sel_o)
    else $error("external ram selected inside mapped window");

  sfr_not_iram_a: assert property (
    dir_req_i.valid && dir_req_i.addr[7]
    |-> !iram_sel_o ##1 ($past(dir_req_i.write) || dir_rvalid_o))
    else $error("upper direct access sent to data ram");

  bit_write_one_a: assert property (
    bit_wr_q |-> $countones(sfr_values_o ^ $past(sfr_values_o)) <= 1)
    else $error("bit write changed more than one bit");

  cfg_decode_a: assert property (
    cfg_wr_q |-> usb_buffer_map_enable_o == cfg_wr_val_q)
    else $error("write at 0x85 did not reach the map enable");

  page_decode_a: assert property (
    in_sfr && dir_req_i.write && !dir_req_i.bit_acc &&
    dir_req_i.addr == 8'haa
    |=> reg_val[sfr_pkg::PAGE_IDX] == ($past(dir_req_i.wdata) & 8'h07))
    else $error("write at 0xaa did not reach the page select");

  cfg_write_fixed_a: assert property (
    cfg_wr_q |-> !reg_val[sfr_pkg::CFG_IDX][7] &&
    reg_val[sfr_pkg::CFG_IDX][5:0] == sfr_pkg::CFG_FIXED[5:0])
    else $error("config constant bits changed by a write");

  lower_to_ram_a: assert property (
    dir_req_i.valid && !dir_req_i.addr[7]
    |-> iram_sel_o ##1 !dir_rvalid_o && !dir_reserved_o)
    else $error("lower direct access not sent to data ram");

  unoccupied_read_a: assert property (
    in_sfr && !dir_req_i.write && !lookup[6]
    |=> dir_reserved_o && dir_rdata_o == 8'h00)
    else $error("unoccupied address answered with data");

  window_write_a: assert property (
    xmov_req_i.valid && xmov_req_i.write && usb_buffer_map_enable_o &&
    in_window && !usb_req_i.valid
    |-> ram_en && ram_we && ram_addr == xmov_req_i.addr[7:0])
    else $error("window write did not reach the buffer");

endmodule : sfr_space_and_fifo_window

// *** bench/core_model.sv ***
// core side model issuing direct and external move requests
`timescale 1ns/1ps
module core_model (
  // clock
  input wire logic clk_i,
  // design answers watched at the taking edge
  input wire logic xmov_ready_i,
  input wire logic iram_sel_i,
  input wire logic [7:0] iram_addr_i,
  input wire logic external_data_ram_sel_i,
  input wire logic [9:0] external_data_ram_addr_i,
  // requests to the design
  output sfr_pkg::dir_req_t dir_req_o,
  output sfr_pkg::xmov_req_t xmov_req_o
);
  logic iram_seen;
  logic external_data_ram_seen;
  logic stalled;
  logic [9:0] xaddr_seen;
  logic [7:0] iaddr_seen;
  logic gave_up = 1'b0;

  // one clock only; the usb side runs on the same clock as the core
  initial begin
    dir_req_o = '0;
    xmov_req_o = '0;
  end

  // one direct access; released fields show the inverse of the last ones
  task automatic dir(input logic w, b, input logic [7:0] a, d);
    @(posedge clk_i);
    dir_req_o <= '{1'b1, w, b, a, d};
    @(posedge clk_i);
    iram_seen = iram_sel_i;
    iaddr_seen = iram_addr_i;
    dir_req_o <= '{1'b0, ~w, ~b, ~a, ~d};
    #1;
  endtask : dir

  // one external move, held until ready is seen high at an edge or 50 stalled edges pass
  task automatic xm(input logic w, p, input logic [15:0] a,
                    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    xmov_req_o <= '{1'b1, w, p, a, d};
    stalled = 1'b0;
    n = 0;
    @(posedge clk_i);
    while (xmov_ready_i !== 1'b1 && n < 50) begin
      stalled = 1'b1;
      n++;
      @(posedge clk_i);
    end
    if (xmov_ready_i !== 1'b1) begin
      gave_up = 1'b1;
    end
    external_data_ram_seen = external_data_ram_sel_i;
    xaddr_seen = external_data_ram_addr_i;
    xmov_req_o <= '{1'b0, ~w, ~p, ~a, ~d};
    #1;
  endtask : xm
endmodule : core_model

// *** bench/tb_top.sv ***
// self-checking bench for the register space and buffer window
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  sfr_pkg::dir_req_t dir_req;
  sfr_pkg::xmov_req_t xmov_req;
  sfr_pkg::buf_req_t usb_req = '0;
  logic [7:0] dir_rdata, xmov_rdata, usb_rdata, iram_addr, d, e;
  logic dir_rvalid, dir_reserved, iram_sel, xmov_ready, xmov_rvalid;
  logic external_data_ram_sel, usb_rvalid, map_en;
  logic [9:0] external_data_ram_addr;
  logic [sfr_pkg::NREG*8-1:0] sfr_values;
  logic [7:0] exp_buf [256];
  logic [7:0] bit_regs [6] = '{8'h80, 8'h90, 8'ha8, 8'hb8, 8'he0, 8'hf0};
  logic [15:0] outside [2] = '{16'h03ff, 16'h0500};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // core clock
  always #10 clk_i = ~clk_i;

  // design and core model
  sfr_space_and_fifo_window i_sfr_space_and_fifo_window (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .dir_req_i(dir_req), .dir_rdata_o(dir_rdata),
    .dir_rvalid_o(dir_rvalid), .dir_reserved_o(dir_reserved),
    .iram_sel_o(iram_sel), .iram_addr_o(iram_addr),
    .sfr_values_o(sfr_values), .usb_buffer_map_enable_o(map_en),
    .xmov_req_i(xmov_req), .xmov_ready_o(xmov_ready),
    .xmov_rdata_o(xmov_rdata), .xmov_rvalid_o(xmov_rvalid),
    .external_data_ram_sel_o(external_data_ram_sel), .external_data_ram_addr_o(external_data_ram_addr),
    .usb_req_i(usb_req), .usb_rdata_o(usb_rdata),
    .usb_rvalid_o(usb_rvalid)
  );
  core_model u_core (
    .clk_i(clk_i), .xmov_ready_i(xmov_ready), .iram_sel_i(iram_sel),
    .iram_addr_i(iram_addr),
    .external_data_ram_sel_i(external_data_ram_sel), .external_data_ram_addr_i(external_data_ram_addr),
    .dir_req_o(dir_req), .xmov_req_o(xmov_req)
  );

  // compare and count
  task automatic check(input string what, input logic [9:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one usb engine access to the buffer
  task automatic ub(input logic w, input logic [7:0] a, v);
    @(posedge clk_i);
    usb_req <= '{1'b1, w, a, v};
    @(posedge clk_i);
    usb_req <= '{1'b0, ~w, ~a, ~v};
    #1;
  endtask : ub

  // value a register holds after a byte write of v
  function automatic logic [7:0] expect_reg(input logic [7:0] a, v);
    if (a == 8'h85) return (v & 8'h40) | 8'h03;
    if (a == 8'haa) return v & 8'h07;
    return v;
  endfunction : expect_reg

  // address holds a register
  function automatic bit mapped(input logic [7:0] a);
    for (int k = 0; k < sfr_pkg::NREG; k++) begin
      if (sfr_pkg::SFR_ADDR[k] == a) return 1'b1;
    end
    return 1'b0;
  endfunction : mapped

  // verdict
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h76b8deb6));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // reset values, random write and read back of every register
    for (int k = 0; k < sfr_pkg::NREG; k++) begin
      u_core.dir(1'b0, 1'b0, sfr_pkg::SFR_ADDR[k], 8'h00);
      e = (k == sfr_pkg::CFG_IDX) ? 8'h03 : 8'h00;
      check("reset value", e, dir_rdata);
      check("read answer", 1'b1, dir_rvalid);
      check("upper select", 1'b0, u_core.iram_seen);
      d = $urandom;
      u_core.dir(1'b1, 1'b0, sfr_pkg::SFR_ADDR[k], d);
      e = expect_reg(sfr_pkg::SFR_ADDR[k], d);
      check("register value", e, sfr_values[k*8+:8]);
      u_core.dir(1'b0, 1'b0, sfr_pkg::SFR_ADDR[k], ~d);
      check("read back", e, dir_rdata);
    end
    // config constant bits ignore a write of the opposite pattern
    u_core.dir(1'b1, 1'b0, 8'h85, 8'hbc);
    u_core.dir(1'b0, 1'b0, 8'h85, 8'h00);
    check("config fixed bits", 8'h03, dir_rdata);
    // unoccupied upper addresses read zero and are flagged
    for (int a = 8'h80; a <= 8'hff; a++) begin
      if (!mapped(a[7:0])) begin
        u_core.dir(1'b1, 1'b0, a[7:0], 8'hff);
        u_core.dir(1'b0, 1'b0, a[7:0], 8'h00);
        check("reserved data", 8'h00, dir_rdata);
        check("reserved flag", 1'b1, dir_reserved);
      end
    end
    // direct accesses below the register space go to data ram
    repeat (8) begin
      d = $urandom_range(8'h7f);
      u_core.dir(1'b0, 1'b0, d, 8'h00);
      check("lower select", 1'b1, u_core.iram_seen);
      check("lower address", d, u_core.iaddr_seen);
      check("lower no answer", 1'b0, dir_rvalid);
    end
    // bit address below the register space lands in the bit ram bytes
    u_core.dir(1'b1, 1'b1, 8'h13, 8'h01);
    check("bit ram select", 1'b1, u_core.iram_seen);
    check("bit ram address", 8'h22, u_core.iaddr_seen);
    // bit write and bit read on each bit addressable register
    foreach (bit_regs[i]) begin
      d = bit_regs[i];
      e = $urandom_range(7);
      u_core.dir(1'b1, 1'b0, d, 8'h00);
      u_core.dir(1'b1, 1'b1, d | e, 8'h01);
      u_core.dir(1'b0, 1'b0, d, 8'h00);
      check("bit write", 8'h01 << e, dir_rdata);
      u_core.dir(1'b0, 1'b1, d | e, 8'h00);
      check("bit read", 8'h01, dir_rdata);
    end
    // fill the buffer from the usb side
    for (int i = 0; i < 256; i++) begin
      exp_buf[i] = $urandom;
      ub(1'b1, i[7:0], exp_buf[i]);
    end
    // mapping off: window goes to ordinary ram
    u_core.dir(1'b1, 1'b0, 8'h85, 8'h00);
    u_core.xm(1'b0, 1'b0, 16'h0410, 8'h00);
    check("off select", 1'b1, u_core.external_data_ram_seen);
    check("off answer", 1'b0, xmov_rvalid);
    check("off address", 10'h010, u_core.xaddr_seen);
    // mapping on: window reads the buffer, ends included
    u_core.dir(1'b1, 1'b0, 8'h85, 8'hff);
    check("map enable", 1'b1, map_en);
    u_core.dir(1'b0, 1'b0, 8'h85, 8'h00);
    check("config enabled", 8'h43, dir_rdata);
    for (int j = 0; j < 12; j++) begin
      d = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($urandom);
      u_core.xm(1'b0, 1'b0, {8'h04, d}, 8'h00);
      check("window data", exp_buf[d], xmov_rdata);
      check("window answer", 1'b1, xmov_rvalid);
      check("window hides ram", 1'b0, u_core.external_data_ram_seen);
    end
    foreach (outside[j]) begin
      u_core.xm(1'b0, 1'b0, outside[j], 8'h00);
      check("outside select", 1'b1, u_core.external_data_ram_seen);
      check("outside address", outside[j][9:0], u_core.xaddr_seen);
    end
    // paged move through the page select, then a write via the window
    u_core.dir(1'b1, 1'b0, 8'haa, 8'hfc);
    d = $urandom;
    u_core.xm(1'b0, 1'b1, {8'h00, d}, 8'h00);
    check("paged data", exp_buf[d], xmov_rdata);
    d = $urandom;
    u_core.xm(1'b1, 1'b0, 16'h0433, d);
    ub(1'b0, 8'h33, 8'h00);
    check("window write", d, usb_rdata);
    check("usb answer", 1'b1, usb_rvalid);
    // usb access wins, the core move waits
    fork
      ub(1'b0, 8'h21, 8'h00);
      u_core.xm(1'b0, 1'b0, 16'h0422, 8'h00);
    join
    check("core stalled", 1'b1, u_core.stalled);
    check("stalled data", exp_buf[8'h22], xmov_rdata);
    // reset in mid-run brings the config back with the mapping off
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    check("reset map off", 1'b0, map_en);
    u_core.dir(1'b0, 1'b0, 8'h85, 8'h00);
    check("reset config", 8'h03, dir_rdata);
    // mapping off again restores ordinary ram
    u_core.dir(1'b1, 1'b0, 8'h85, 8'h00);
    u_core.xm(1'b0, 1'b0, 16'h0400, 8'h00);
    check("unmapped select", 1'b1, u_core.external_data_ram_seen);
    check("move limit", 1'b0, u_core.gave_up);
    results();
  end
endmodule : tb_top
